// file: logic/bus_cycle_seq.sv
// cycle-by-cycle bus sequencer for the 8-bit processor bus
//
// Contract
// - interrupt service starts 12 cycles after instruction end, 4 after wait.
// - every cycle drives address, strobe and read/write; idle cycles strobe low, read; test-memory final cycle and reset bus: strobe low, write level.
// - immediate 8-bit 2 cycles; 16-bit 3 cycles, high byte first.
// - direct reads 3 cycles; 16-bit 4 cycles, high then low byte.
// - direct accumulator store: opcode, address, idle at destination, write.
// - 16-bit register stores write high then low; 5 direct, 7 indexed.
// - indexed: offset, idle at index, idle at index plus offset no carry.
// - indexed reads after two idle cycles; 5 cycles, 16-bit 6 cycles.
// - indexed accumulator store 6 cycles, idle three to five, write sixth.
// - read-modify-write: read, idle, write; 7 indexed, 6 extended.
// - indexed call 8 cycles, pushes low then high return byte, then idles.
// - extended jump 3 cycles, target high then low byte.
// - extended reads fetch 16-bit address high first; 4 or 5 cycles.
// - extended accumulator store 5 cycles with one idle before write.
// - test-memory final cycle keeps strobe low, operand unchanged.
module bus_cycle_seq
   import seq_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        cyc_en,
   input  wire logic        instr_valid,
   input  wire instr_t      instr,
   input  wire logic        irq_req,
   input  wire logic        after_wait,
   input  wire logic [7:0]  data_in,
   output logic             instr_ready,
   output bus_cycle_t       bus,
   output logic [7:0]       rd_data,
   output logic             rd_strobe,
   output logic             instr_done,
   output logic             irq_enter
);
   typedef struct packed {
      logic        busy;
      instr_t      cur;
      logic [3:0]  cyc;
      logic [7:0]  hi_byte;
      logic [7:0]  offs;
      bus_cycle_t  bus;
      logic [7:0]  rd_data;
      logic        rd_strobe;
   } seq_state_t;

   seq_state_t st_ff;
   seq_state_t nxt_st;
   logic       last_cyc;
   logic       irq_pending_ff;
   logic       irq_meta_ff;
   logic       irq_sync_ff;
   logic [7:0] din_meta_ff;
   logic [7:0] din_sync_ff;

   // total machine cycles per group
   function automatic logic [3:0] cycles_of(input op_group_t g);
      case (g)
         OP_IMM8:     cycles_of = 4'h2;
         OP_IMM16:    cycles_of = 4'h3;
         OP_DIR_RD8:  cycles_of = 4'h3;
         OP_DIR_RD16: cycles_of = 4'h4;
         OP_DIR_ST8:  cycles_of = 4'h4;
         OP_DIR_ST16: cycles_of = 4'h5;
         OP_IDX_JMP:  cycles_of = 4'h4;
         OP_IDX_RD8:  cycles_of = 4'h5;
         OP_IDX_RD16: cycles_of = 4'h6;
         OP_IDX_ST8:  cycles_of = 4'h6;
         OP_IDX_ST16: cycles_of = 4'h7;
         OP_IDX_RMW:  cycles_of = 4'h7;
         OP_IDX_CALL: cycles_of = 4'h8;
         OP_EXT_JMP:  cycles_of = 4'h3;
         OP_EXT_RD8:  cycles_of = 4'h4;
         OP_EXT_RD16: cycles_of = 4'h5;
         OP_EXT_ST8:  cycles_of = 4'h5;
         OP_EXT_ST16: cycles_of = 4'h6;
         OP_EXT_RMW:  cycles_of = 4'h6;
         default:     cycles_of = 4'h2;
      endcase
   endfunction

   function automatic bus_cycle_t mk(input logic [15:0] a, input logic v, input logic rw,
                                     input logic [7:0] d);
      mk.addr             = a;
      mk.valid_mem_access = v;
      mk.rd_wr            = rw;
      mk.dout             = rw ? DATA_RESET : d;
      mk.dout_oe          = ~rw;
   endfunction

   // idle cycle: strobe low, read level, data released
   function automatic bus_cycle_t idle(input logic [15:0] a);
      idle = mk(a, 1'b0, 1'b1, DATA_RESET);
   endfunction

   // builds the bus image of cycle n (1-based) for the instruction
   function automatic bus_cycle_t plan_cycle(input instr_t c, input logic [3:0] n,
                                             input logic [7:0] hi, input logic [7:0] offs);
      logic [15:0] dir_a;
      logic [15:0] ext_a;
      logic [15:0] idx_nc;
      logic [15:0] idx_c;
      logic [15:0] pc1;
      logic [15:0] pc2;
      dir_a   = {8'h00, offs};
      ext_a   = {hi, offs};
      idx_nc  = {c.index_reg[15:8], 8'(c.index_reg[7:0] + offs)};
      idx_c   = 16'(c.index_reg + {8'h00, offs});
      pc1     = 16'(c.pc + 16'h0001);
      pc2     = 16'(c.pc + 16'h0002);
      plan_cycle = mk(c.pc, 1'b1, 1'b1, DATA_RESET);
      if (n == 4'h2) begin
         plan_cycle = mk(pc1, 1'b1, 1'b1, DATA_RESET);
      end else if (n != 4'h1) begin
         case (c.group)
            OP_IMM16: plan_cycle = mk(pc2, 1'b1, 1'b1, DATA_RESET);
            OP_DIR_RD8, OP_DIR_RD16:
               plan_cycle = mk(n == 4'h3 ? dir_a : 16'(dir_a + 16'h0001),
                               1'b1, 1'b1, DATA_RESET);
            OP_DIR_ST8:
               plan_cycle = (n == 4'h3) ? idle(dir_a)
                          : mk(dir_a, 1'b1, 1'b0, c.wr_data[7:0]);
            OP_DIR_ST16:
               plan_cycle = (n == 4'h3) ? idle(dir_a)
                          : (n == 4'h4) ? mk(dir_a, 1'b1, 1'b0, c.wr_data[15:8])
                          : mk(16'(dir_a + 16'h0001), 1'b1, 1'b0, c.wr_data[7:0]);
            OP_IDX_JMP, OP_IDX_RD8, OP_IDX_RD16, OP_IDX_ST8, OP_IDX_ST16, OP_IDX_RMW: begin
               if (n == 4'h3) plan_cycle = idle(c.index_reg);
               else if (n == 4'h4) plan_cycle = idle(idx_nc);
               else if (c.group == OP_IDX_RD8 || c.group == OP_IDX_RD16)
                  plan_cycle = mk(n == 4'h5 ? idx_c : 16'(idx_c + 16'h0001),
                                  1'b1, 1'b1, DATA_RESET);
               else if (c.group == OP_IDX_ST8)
                  plan_cycle = (n == 4'h5) ? idle(idx_c)
                             : mk(idx_c, 1'b1, 1'b0, c.wr_data[7:0]);
               else if (c.group == OP_IDX_ST16)
                  plan_cycle = (n == 4'h5) ? idle(idx_c)
                             : (n == 4'h6) ? mk(idx_c, 1'b1, 1'b0, c.wr_data[15:8])
                             : mk(16'(idx_c + 16'h0001), 1'b1, 1'b0, c.wr_data[7:0]);
               else
                  plan_cycle = (n == 4'h5) ? mk(idx_c, 1'b1, 1'b1, DATA_RESET)
                             : (n == 4'h6) ? idle(idx_c)
                             : mk(idx_c, ~c.test_only, 1'b0, c.wr_data[7:0]);
            end
            OP_IDX_CALL: begin
               case (n)
                  4'h3: plan_cycle = idle(c.index_reg);
                  4'h4: plan_cycle = mk(c.stack_ptr, 1'b1, 1'b0, pc2[7:0]);
                  4'h5: plan_cycle = mk(16'(c.stack_ptr - 16'h0001), 1'b1, 1'b0,
                                        pc2[15:8]);
                  4'h6: plan_cycle = idle(16'(c.stack_ptr - 16'h0002));
                  4'h7: plan_cycle = idle(c.index_reg);
                  default: plan_cycle = idle(idx_nc);
               endcase
            end
            OP_EXT_JMP: plan_cycle = mk(pc2, 1'b1, 1'b1, DATA_RESET);
            default: begin
               if (n == 4'h3) plan_cycle = mk(pc2, 1'b1, 1'b1, DATA_RESET);
               else if (c.group == OP_EXT_RD8 || c.group == OP_EXT_RD16)
                  plan_cycle = mk(n == 4'h4 ? ext_a : 16'(ext_a + 16'h0001),
                                  1'b1, 1'b1, DATA_RESET);
               else if (c.group == OP_EXT_ST8)
                  plan_cycle = (n == 4'h4) ? idle(ext_a)
                             : mk(ext_a, 1'b1, 1'b0, c.wr_data[7:0]);
               else if (c.group == OP_EXT_ST16)
                  plan_cycle = (n == 4'h4) ? idle(ext_a)
                             : (n == 4'h5) ? mk(ext_a, 1'b1, 1'b0, c.wr_data[15:8])
                             : mk(16'(ext_a + 16'h0001), 1'b1, 1'b0, c.wr_data[7:0]);
               else
                  plan_cycle = (n == 4'h4) ? mk(ext_a, 1'b1, 1'b1, DATA_RESET)
                             : (n == 4'h5) ? idle(ext_a)
                             : mk(ext_a, ~c.test_only, 1'b0, c.wr_data[7:0]);
            end
         endcase
      end
   endfunction

   assign last_cyc    = st_ff.busy && (st_ff.cyc == cycles_of(st_ff.cur.group));
   assign instr_ready = !st_ff.busy || (last_cyc && cyc_en);
   assign bus         = st_ff.bus;
   assign rd_data     = st_ff.rd_data;
   assign rd_strobe   = st_ff.rd_strobe;
   assign instr_done  = last_cyc && cyc_en;

   always_comb begin
      nxt_st           = st_ff;
      nxt_st.rd_strobe = 1'b0;
      if (cyc_en && st_ff.busy) begin
         // sample only strobed read cycles
         if (st_ff.bus.valid_mem_access && st_ff.bus.rd_wr) begin
            nxt_st.rd_data   = din_sync_ff;
            nxt_st.rd_strobe = 1'b1;
            if (st_ff.cyc == 4'h2) nxt_st.offs = din_sync_ff;
            if (st_ff.cyc == 4'h2) nxt_st.hi_byte = din_sync_ff;
            // cycle 3 carries an address byte in extended mode only
            if (st_ff.cyc == 4'h3 && st_ff.cur.group >= OP_EXT_JMP) nxt_st.offs = din_sync_ff;
         end
      end
      if (cyc_en) begin
         if (instr_valid && instr_ready) begin
            nxt_st.busy = 1'b1;
            nxt_st.cur  = instr;
            nxt_st.cyc  = 4'h1;
            nxt_st.bus  = mk(instr.pc, 1'b1, 1'b1, DATA_RESET);
         end else if (st_ff.busy && !last_cyc) begin
            nxt_st.cyc = st_ff.cyc + 4'h1;
            nxt_st.bus = plan_cycle(st_ff.cur, 4'(st_ff.cyc + 4'h1),
                                    nxt_st.hi_byte, nxt_st.offs);
         end else begin
            nxt_st.busy = 1'b0;
            nxt_st.bus  = idle(st_ff.bus.addr);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_ff          <= '0;
         irq_pending_ff <= 1'b0;
         irq_meta_ff    <= 1'b0;
         irq_sync_ff    <= 1'b0;
         din_meta_ff    <= DATA_RESET;
         din_sync_ff    <= DATA_RESET;
      end else begin
         st_ff          <= nxt_st;
         din_meta_ff    <= data_in;
         din_sync_ff    <= din_meta_ff;
         irq_meta_ff    <= irq_req;
         irq_sync_ff    <= irq_meta_ff;
         // armed only at an instruction end; a held request re-arms at every instruction end
         irq_pending_ff <= irq_sync_ff && instr_done;
      end
   end

   int_latency u_int_latency (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .cyc_en     (cyc_en),
      .start      (irq_pending_ff),
      .after_wait (after_wait),
      .irq_enter  (irq_enter)
   );
endmodule // bus_cycle_seq

// file: logic/int_latency.sv
// interrupt entry latency counter
module int_latency
   import seq_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic cyc_en,
   input  wire logic start,
   input  wire logic after_wait,
   output logic      irq_enter
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       busy;
   } lat_state_t;

   lat_state_t st_ff;
   lat_state_t nxt_st;

   always_comb begin
      nxt_st    = st_ff;
      irq_enter = 1'b0;
      if (start && !st_ff.busy) begin
         nxt_st.busy = 1'b1;
         nxt_st.cnt  = after_wait ? 4'(INT_LATENCY_WAIT - 1) : 4'(INT_LATENCY - 1);
      end else if (st_ff.busy && cyc_en) begin
         if (st_ff.cnt == INT_CNT_RESET) begin
            nxt_st.busy = 1'b0;
            irq_enter   = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt - 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_ff <= '{cnt: INT_CNT_RESET, busy: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule // int_latency

// file: logic/seq_pkg.sv
// shared types and constants for the bus cycle sequencer
package seq_pkg;
   localparam int unsigned INT_LATENCY      = 12;
   localparam int unsigned INT_LATENCY_WAIT = 4;
   localparam logic [3:0]  INT_CNT_RESET    = 4'h0;
   localparam logic [15:0] ADDR_RESET       = 16'h0000;
   localparam logic [7:0]  DATA_RESET       = 8'h00;
   localparam logic [15:0] SP_RESET         = 16'h0000;

   // instruction groups sequenced by this block
   typedef enum logic [4:0] {
      OP_IMM8, OP_IMM16, OP_DIR_RD8, OP_DIR_RD16, OP_DIR_ST8, OP_DIR_ST16,
      OP_IDX_JMP, OP_IDX_RD8, OP_IDX_RD16, OP_IDX_ST8, OP_IDX_ST16, OP_IDX_RMW,
      OP_IDX_CALL, OP_EXT_JMP, OP_EXT_RD8, OP_EXT_RD16, OP_EXT_ST8, OP_EXT_ST16,
      OP_EXT_RMW
   } op_group_t;

   // one machine cycle of bus signalling
   typedef struct packed {
      logic [15:0] addr;
      logic        valid_mem_access;
      logic        rd_wr;
      logic [7:0]  dout;
      logic        dout_oe;
   } bus_cycle_t;

   // instruction issued to the sequencer
   typedef struct packed {
      op_group_t   group;
      logic        test_only;
      logic [15:0] pc;
      logic [15:0] index_reg;
      logic [15:0] stack_ptr;
      logic [15:0] wr_data;
   } instr_t;
endpackage

// file: tb/bus_cycle_seq_checker.sv
// concurrent checks on the bus cycle sequencer ports
module bus_cycle_seq_checker
   import seq_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       cyc_en,
   input wire logic       instr_valid,
   input wire instr_t     instr,
   input wire logic       irq_req,
   input wire logic       after_wait,
   input wire logic [7:0] data_in,
   input wire logic       instr_ready,
   input wire bus_cycle_t bus,
   input wire logic [7:0] rd_data,
   input wire logic       rd_strobe,
   input wire logic       instr_done,
   input wire logic       irq_enter
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic taken  = cyc_en && instr_valid && instr_ready;
   wire logic wr_cyc = bus.valid_mem_access && !bus.rd_wr;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   chk_oe_on_write: assert property (bus.dout_oe |-> !bus.rd_wr)
      else $error("data bus driven on a read cycle");
   chk_write_drives: assert property (wr_cyc |-> bus.dout_oe)
      else $error("strobed write without data drive");
   chk_bus_stands: assert property (!cyc_en |=> $stable(bus))
      else $error("bus changed inside a machine cycle");
   chk_done_at_end: assert property (instr_done && !instr_valid |=> !bus.valid_mem_access && bus.rd_wr)
      else $error("no idle cycle after the last cycle");
   chk_read_capture: assert property (cyc_en && bus.valid_mem_access && bus.rd_wr |=> rd_strobe && rd_data == $past(data_in, 3))
      else $error("strobed read byte not captured");
   chk_fetch_at_pc: assert property (taken |=> bus.addr == $past(instr.pc) && bus.rd_wr)
      else $error("first cycle not an opcode read at pc");
   chk_busy_after: assert property (taken |=> !instr_ready [*2])
      else $error("ready while an instruction runs");
   chk_idle_first: assert property (cyc_en && bus.rd_wr ##1 wr_cyc |-> !$past(bus.valid_mem_access))
      else $error("write not preceded by an idle cycle");
   chk_irq_pending: assert property (irq_enter |-> irq_req)
      else $error("interrupt entry with nothing pending");
endmodule // bus_cycle_seq_checker

bind bus_cycle_seq bus_cycle_seq_checker bus_cycle_seq_checker_inst (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .cyc_en(cyc_en), .instr_valid(instr_valid),
   .instr(instr), .irq_req(irq_req), .after_wait(after_wait), .data_in(data_in),
   .instr_ready(instr_ready), .bus(bus), .rd_data(rd_data), .rd_strobe(rd_strobe),
   .instr_done(instr_done), .irq_enter(irq_enter));

// file: tb/cpu_bus_cycle_sequencer_tb_top.sv
// self-checking bench for the bus cycle sequencer
module cpu_bus_cycle_sequencer_tb_top
   import seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] IX = 16'h12F0;
   localparam logic [15:0] SP = 16'h01F0;
   localparam logic [15:0] WD = 16'hC35A;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, cyc_en = 1'b0, instr_valid = 1'b0;
   logic        irq_req = 1'b0, after_wait = 1'b0, rec = 1'b0;
   logic        instr_ready, rd_strobe, instr_done, irq_enter;
   instr_t      instr = '0;
   bus_cycle_t  bus;
   logic [7:0]  data_in, rd_data;
   logic [1:0]  div = 2'h0;
   logic [15:0] e_ix, nc_ix;
   logic [17:0] exp_q[$], got_q[$];
   int          err_total = 0, n_compared = 0, cycles = 0, irq_cnt = 0, irq_lat = 0;

   bus_cycle_seq bus_cycle_seq_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .cyc_en(cyc_en),
      .instr_valid(instr_valid), .instr(instr), .irq_req(irq_req), .after_wait(after_wait),
      .data_in(data_in), .instr_ready(instr_ready), .bus(bus), .rd_data(rd_data),
      .rd_strobe(rd_strobe), .instr_done(instr_done), .irq_enter(irq_enter));
   mem_model mem_model_inst (.clk_sys(clk_sys), .cyc_en(cyc_en), .bus(bus), .data_in(data_in));

   always #2.5 clk_sys = ~clk_sys;
   // one machine cycle per 4 clocks: read data needs 2 flops to land
   always @(posedge clk_sys) begin
      div <= div + 2'h1;
      cyc_en <= (div == 2'h2);
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   always @(posedge clk_sys) begin
      if (cyc_en) irq_cnt <= irq_cnt + 1;
      if (irq_enter && irq_lat == 0) irq_lat <= irq_cnt + int'(cyc_en);
      if (rec && cyc_en) begin
         got_q.push_back({bus.addr, bus.valid_mem_access, bus.rd_wr});
         if (instr_done) begin
            rec <= 1'b0;
            irq_cnt <= 0;
         end
      end
   end

   task automatic check(input logic [17:0] seen, input logic [17:0] expd);
      n_compared++;
      if (seen !== expd) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask
   function automatic logic [7:0] m(input logic [15:0] a);
      return mem_model_inst.mb(a);
   endfunction
   task automatic cy(input logic [15:0] a, input logic [1:0] k);
      exp_q.push_back({a, k});
   endtask
   task automatic pre(input logic [15:0] pc, input int n);
      for (int i = 0; i < n; i++) cy(pc + 16'(i), 2'h3);
   endtask
   task automatic head(input logic [15:0] pc);
      pre(pc, 2);
      cy(IX, 2'h1);
      cy(nc_ix, 2'h1);
   endtask
   task automatic exec(input op_group_t g, input logic t, input logic [15:0] pc);
      got_q.delete();
      instr <= '{g, t, pc, IX, SP, WD};
      instr_valid <= 1'b1;
      @(posedge clk_sys iff (cyc_en && instr_ready));
      instr_valid <= 1'b0;
      rec <= 1'b1;
      do @(posedge clk_sys); while (rec);
      check(18'(got_q.size()), 18'(exp_q.size()));
      foreach (exp_q[i]) check(got_q[i], exp_q[i]);
      exp_q.delete();
   endtask

   task automatic t_imm;
      pre(16'h0100, 3);
      exec(OP_IMM16, 1'b0, 16'h0100);
      pre(16'h0100, 2);
      exec(OP_IMM8, 1'b0, 16'h0100);
   endtask
   task automatic t_dir;
      logic [15:0] a;
      a = {8'h00, m(16'h0201)};
      pre(16'h0200, 2);
      cy(a, 2'h3);
      cy(a + 16'h1, 2'h3);
      exec(OP_DIR_RD16, 1'b0, 16'h0200);
      check(18'(rd_data), 18'(m(a + 16'h1)));
      pre(16'h0200, 2);
      cy(a, 2'h3);
      exec(OP_DIR_RD8, 1'b0, 16'h0200);
      check(18'(rd_data), 18'(m(a)));
      pre(16'h0200, 2);
      cy(a, 2'h1);
      cy(a, 2'h2);
      cy(a + 16'h1, 2'h2);
      exec(OP_DIR_ST16, 1'b0, 16'h0200);
      check(18'(m(a)), 18'(WD[15:8]));
      check(18'(m(a + 16'h1)), 18'(WD[7:0]));
   endtask
   task automatic t_idx;
      e_ix = IX + 16'(m(16'h0301));
      nc_ix = {IX[15:8], e_ix[7:0]};
      head(16'h0300);
      exec(OP_IDX_JMP, 1'b0, 16'h0300);
      head(16'h0300);
      cy(e_ix, 2'h3);
      exec(OP_IDX_RD8, 1'b0, 16'h0300);
      head(16'h0300);
      cy(e_ix, 2'h3);
      cy(e_ix + 16'h1, 2'h3);
      exec(OP_IDX_RD16, 1'b0, 16'h0300);
      head(16'h0300);
      cy(e_ix, 2'h1);
      cy(e_ix, 2'h2);
      cy(e_ix + 16'h1, 2'h2);
      exec(OP_IDX_ST16, 1'b0, 16'h0300);
      check(18'(m(e_ix)), 18'(WD[15:8]));
      check(18'(m(e_ix + 16'h1)), 18'(WD[7:0]));
      head(16'h0300);
      cy(e_ix, 2'h1);
      cy(e_ix, 2'h2);
      exec(OP_IDX_ST8, 1'b0, 16'h0300);
      check(18'(m(e_ix)), 18'(WD[7:0]));
      // a byte that a leaked write would overwrite
      mem_model_inst.mem[e_ix] = 8'hA5;
      head(16'h0300);
      cy(e_ix, 2'h3);
      cy(e_ix, 2'h1);
      cy(e_ix, 2'h0);
      exec(OP_IDX_RMW, 1'b1, 16'h0300);
      check(18'(m(e_ix)), 18'h000A5);
   endtask
   task automatic t_call;
      pre(16'h0300, 2);
      cy(IX, 2'h1);
      cy(SP, 2'h2);
      cy(SP - 16'h1, 2'h2);
      cy(SP - 16'h2, 2'h1);
      cy(IX, 2'h1);
      cy(nc_ix, 2'h1);
      exec(OP_IDX_CALL, 1'b0, 16'h0300);
      check(18'(m(SP)), 18'h02);
      check(18'(m(SP - 16'h1)), 18'h03);
   endtask
   task automatic t_ext;
      logic [15:0] a;
      a = {m(16'h0401), m(16'h0402)};
      pre(16'h0400, 3);
      exec(OP_EXT_JMP, 1'b0, 16'h0400);
      pre(16'h0400, 3);
      cy(a, 2'h3);
      exec(OP_EXT_RD8, 1'b0, 16'h0400);
      pre(16'h0400, 3);
      cy(a, 2'h3);
      cy(a + 16'h1, 2'h3);
      exec(OP_EXT_RD16, 1'b0, 16'h0400);
      check(18'(rd_data), 18'(m(a + 16'h1)));
      pre(16'h0400, 3);
      cy(a, 2'h1);
      cy(a, 2'h2);
      cy(a + 16'h1, 2'h2);
      exec(OP_EXT_ST16, 1'b0, 16'h0400);
      check(18'(m(a)), 18'(WD[15:8]));
      check(18'(m(a + 16'h1)), 18'(WD[7:0]));
      pre(16'h0400, 3);
      cy(a, 2'h3);
      cy(a, 2'h1);
      cy(a, 2'h2);
      exec(OP_EXT_RMW, 1'b0, 16'h0400);
      mem_model_inst.mem[a] = 8'hA5;
      pre(16'h0400, 3);
      cy(a, 2'h1);
      cy(a, 2'h2);
      exec(OP_EXT_ST8, 1'b0, 16'h0400);
      check(18'(m(a)), 18'(WD[7:0]));
   endtask
   task automatic t_irq(input logic aw, input int unsigned lat);
      after_wait <= aw;
      irq_req <= 1'b1;
      irq_lat <= 0;
      pre(16'h0100, 2);
      exec(OP_IMM8, 1'b0, 16'h0100);
      for (int i = 0; i < 100 && irq_lat == 0; i++) @(posedge clk_sys);
      irq_req <= 1'b0;
      check(18'(irq_lat), 18'(lat));
   endtask
   task automatic tally_and_finish;
      if (err_total == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_imm();
      t_dir();
      t_idx();
      t_call();
      t_ext();
      t_irq(1'b0, INT_LATENCY);
      t_irq(1'b1, INT_LATENCY_WAIT);
      tally_and_finish();
   end
endmodule // cpu_bus_cycle_sequencer_tb_top

// file: tb/mem_model.sv
// memory and peripheral model on the far side of the system bus
module mem_model
   import seq_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       cyc_en,
   input  wire bus_cycle_t bus,
   output logic [7:0]      data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [15:0]];
   logic [7:0] last_q = 8'h00;
   function automatic logic [7:0] mb(input logic [15:0] a);
      return mem.exists(a) ? mem[a] : a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5A;
   endfunction
   // idle cycles see the inverse, so a stale byte can never pass
   assign data_in = (bus.valid_mem_access && bus.rd_wr) ? mb(bus.addr) : ~last_q;
   always @(posedge clk_sys) begin
      if (cyc_en && bus.valid_mem_access && bus.rd_wr) last_q <= mb(bus.addr);
      if (cyc_en && bus.valid_mem_access && !bus.rd_wr) mem[bus.addr] = bus.dout;
   end
endmodule // mem_model
